// *** verilog/iad_top.sv ***
// Behaviour
// - halfword abs uses low 16 bits; values up to 0x7fff pass unchanged
// - low halfword 0x8000 saturates to 0x0000_7fff and raises saturation
// - halfword abs flags: Z from source zero, N bit 31, V sat, S sticky
// - commands change flags only when the set-flags bit is set
// - add with carry writes a+b+C and sets Z, N, C, V
// - plain add writes a+b and sets Z, N, C, V
// - conditional forms write the destination only when the condition holds
// - scaled sum shifts second source left by one before adding
// - scaled sum shifts second source left by two before adding
// - scaled sum shifts second source left by three before adding
// - scaled sum overflow reflects only the add step
// - short pointer offsets encode five bits, low two bits are zero
module iad_top
    import iad_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [SW-1:0] wb_sel_i,
    input wire logic [DW-1:0] wb_dat_i,
    output logic [DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [FLG_W-1:0] flags_o
);

    logic ack_r;
    logic [DW-1:0] dat_r;
    logic [DW-1:0] src1_r;
    logic [DW-1:0] src2_r;
    logic [DW-1:0] limm_r;
    logic [DW-1:0] result_r;
    logic [FLG_W-1:0] flags_r;
    logic [FLG_W-1:0] flags_nxt;
    logic [NREGS-1:0][DW-1:0] rf_r;

    wire req = wb_cyc_i && wb_stb_i && !ack_r;
    wire wr = req && wb_we_i;
    wire hit_rf = (wb_adr_i & ADR_RF_MASK) == ADR_RF_BASE;
    wire [REG_IDX_W-1:0] rf_rd_idx = wb_adr_i[ADR_WORD_LSB +: REG_IDX_W];
    wire cmd_wr = wr && (wb_adr_i == ADR_CMD);
    wire flags_wr = wr && (wb_adr_i == ADR_FLAGS);
    wire [DW-1:0] cmd = iad_merge(WORD_ZERO, wb_dat_i, wb_sel_i);

    // command decode
    wire iad_op_t op = iad_op_t'(cmd[CMD_OP_LSB +: CMD_OP_W]);
    wire setf = cmd[CMD_SETF_BIT];
    wire [CMD_COND_W-1:0] cond = cmd[CMD_COND_LSB +: CMD_COND_W];
    wire [REG_IDX_W-1:0] dest = cmd[CMD_DEST_LSB +: REG_IDX_W];
    wire src1_limm = cmd[CMD_SRC1_LIMM_BIT];
    wire src2_limm = cmd[CMD_SRC2_LIMM_BIT];
    wire short_off = cmd[CMD_SHORT_OFF_BIT];
    wire [OFF_W-1:0] off5 = cmd[CMD_OFF_LSB +: OFF_W];
    wire [DW-1:0] off_word = {{(DW-OFF_W-OFF_ALIGN_W){1'b0}}, off5, {OFF_ALIGN_W{1'b0}}};

    wire [DW-1:0] op1 = src1_limm ? limm_r : src1_r;
    wire [DW-1:0] op2 = short_off ? off_word : (src2_limm ? limm_r : src2_r);
    wire cond_ok = iad_cond_true(cond, flags_r);
    wire exec = cmd_wr && cond_ok;
    wire rf_we = exec && (dest != '0);
    wire flag_upd = exec && setf;

    logic [DW-1:0] alu_res;
    logic alu_z;
    logic alu_n;
    logic alu_c;
    logic alu_v;
    logic alu_sat;

    iad_alu u_alu (
        .op_i(op),
        .a_i(op1),
        .b_i(op2),
        .carry_i(flags_r[FLG_C]),
        .res_o(alu_res),
        .z_o(alu_z),
        .n_o(alu_n),
        .c_o(alu_c),
        .v_o(alu_v),
        .sat_o(alu_sat)
    );

    wire [DW-1:0] flags_bus = iad_merge({{(DW-FLG_W){1'b0}}, flags_r}, wb_dat_i, wb_sel_i);

    // sticky saturation only accumulates on commands; a flags register write can clear it
    assign flags_nxt = flags_wr ? flags_bus[FLG_W-1:0] :
                       flag_upd ? {flags_r[FLG_S] | alu_sat, alu_v, alu_c, alu_n, alu_z} :
                       flags_r;

    wire [DW-1:0] rd_mux = (wb_adr_i == ADR_SRC1) ? src1_r :
                           (wb_adr_i == ADR_SRC2) ? src2_r :
                           (wb_adr_i == ADR_LIMM) ? limm_r :
                           (wb_adr_i == ADR_RESULT) ? result_r :
                           (wb_adr_i == ADR_FLAGS) ? {{(DW-FLG_W){1'b0}}, flags_r} :
                           hit_rf ? rf_r[rf_rd_idx] :
                           WORD_ZERO;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
            dat_r <= WORD_ZERO;
        end else begin
            ack_r <= req;
            dat_r <= (req && !wb_we_i) ? rd_mux : WORD_ZERO;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            src1_r <= WORD_ZERO;
            src2_r <= WORD_ZERO;
            limm_r <= WORD_ZERO;
        end else if (wr) begin
            if (wb_adr_i == ADR_SRC1) src1_r <= iad_merge(src1_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == ADR_SRC2) src2_r <= iad_merge(src2_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == ADR_LIMM) limm_r <= iad_merge(limm_r, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            flags_r <= FLAGS_RST;
            result_r <= WORD_ZERO;
        end else begin
            flags_r <= flags_nxt;
            if (exec) result_r <= alu_res;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rf_r <= '0;
        end else if (rf_we) begin
            rf_r[dest] <= alu_res;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign flags_o = flags_r;

    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_run(iad_op_t o);
        exec && (op == o);
    endsequence

    sequence s_run_flags(iad_op_t o);
        s_run(o) ##0 setf;
    endsequence

    property p_abs_pass;
        s_run(OP_HALFWORD_ABS_SATURATE) ##0 (op1[HALF_W-1:0] <= HALF_MAX)
            |=> result_r == {HALF_ZERO, $past(op1[HALF_W-1:0])};
    endproperty
    a_abs_pass: assert property (p_abs_pass) else $error("abs pass-through wrong");

    // only the low halfword ever reaches the result
    property p_abs_upper;
        s_run(OP_HALFWORD_ABS_SATURATE) |=> result_r[DW-1:HALF_W] == HALF_ZERO;
    endproperty
    a_abs_upper: assert property (p_abs_upper) else $error("abs upper half not zero");

    property p_abs_sat;
        s_run_flags(OP_HALFWORD_ABS_SATURATE) ##0 (op1[HALF_W-1:0] == HALF_MIN)
            |=> (result_r == {HALF_ZERO, HALF_MAX}) && flags_r[FLG_V] && flags_r[FLG_S];
    endproperty
    a_abs_sat: assert property (p_abs_sat) else $error("abs saturation wrong");

    property p_abs_flags;
        s_run_flags(OP_HALFWORD_ABS_SATURATE)
            |=> (flags_r[FLG_Z] == ($past(op1) == WORD_ZERO)) && (flags_r[FLG_N] == $past(op1[DW-1]))
                && (flags_r[FLG_C] == $past(flags_r[FLG_C]));
    endproperty
    a_abs_flags: assert property (p_abs_flags) else $error("abs flags wrong");

    property p_noflag;
        cmd_wr && !setf |=> flags_r == $past(flags_r);
    endproperty
    a_noflag: assert property (p_noflag) else $error("flags changed without set-flags");

    property p_adc;
        s_run_flags(OP_SUM_WITH_CARRY)
            |=> result_r == DW'($past(op1) + $past(op2) + DW'($past(flags_r[FLG_C])));
    endproperty
    a_adc: assert property (p_adc) else $error("carry sum wrong");

    property p_adc_carry;
        s_run_flags(OP_SUM_WITH_CARRY)
            |=> {flags_r[FLG_C], result_r} == ({1'b0, $past(op1)} + {1'b0, $past(op2)}
                + (DW+1)'($past(flags_r[FLG_C])));
    endproperty
    a_adc_carry: assert property (p_adc_carry) else $error("carry sum carry out wrong");

    property p_add_carry;
        s_run_flags(OP_SUM)
            |=> (result_r == DW'($past(op1) + $past(op2)))
                && (flags_r[FLG_C] == (result_r < $past(op1)));
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("sum or carry wrong");

    property p_add_znv;
        s_run_flags(OP_SUM)
            |=> (flags_r[FLG_Z] == (result_r == WORD_ZERO)) && (flags_r[FLG_N] == result_r[DW-1])
                && (flags_r[FLG_V] == (($past(op1[DW-1]) == $past(op2[DW-1]))
                && (result_r[DW-1] != $past(op1[DW-1]))));
    endproperty
    a_add_znv: assert property (p_add_znv) else $error("sum zero, sign or overflow wrong");

    property p_cond_false;
        cmd_wr && !cond_ok |=> $stable(rf_r) && $stable(result_r);
    endproperty
    a_cond_false: assert property (p_cond_false) else $error("write despite false condition");

    property p_scale2;
        s_run(OP_SUM_SCALED_BY_TWO) |=> result_r == DW'($past(op1) + ($past(op2) << 1));
    endproperty
    a_scale2: assert property (p_scale2) else $error("scale by two wrong");

    property p_scale4;
        s_run(OP_SUM_SCALED_BY_FOUR) |=> result_r == DW'($past(op1) + ($past(op2) << 2));
    endproperty
    a_scale4: assert property (p_scale4) else $error("scale by four wrong");

    property p_scale8;
        s_run(OP_SUM_SCALED_BY_EIGHT) |=> result_r == DW'($past(op1) + ($past(op2) << 3));
    endproperty
    a_scale8: assert property (p_scale8) else $error("scale by eight wrong");

    property p_scale_ovf;
        s_run_flags(OP_SUM_SCALED_BY_EIGHT)
            |=> flags_r[FLG_V] == (($past(op1[DW-1]) == $past(op2[DW-4])) && (result_r[DW-1] != $past(op1[DW-1])));
    endproperty
    a_scale_ovf: assert property (p_scale_ovf) else $error("scaled overflow wrong");

    property p_scale2_ovf;
        s_run_flags(OP_SUM_SCALED_BY_TWO)
            |=> flags_r[FLG_V] == (($past(op1[DW-1]) == $past(op2[DW-2])) && (result_r[DW-1] != $past(op1[DW-1])));
    endproperty
    a_scale2_ovf: assert property (p_scale2_ovf) else $error("scaled by two overflow wrong");

    property p_short_off;
        cmd_wr && short_off |-> (op2[OFF_ALIGN_W-1:0] == '0) && (op2 >> (OFF_W + OFF_ALIGN_W)) == '0;
    endproperty
    a_short_off: assert property (p_short_off) else $error("short offset not aligned");

    property p_zero_dest;
        cmd_wr && (dest == '0) |=> $stable(rf_r);
    endproperty
    a_zero_dest: assert property (p_zero_dest) else $error("zero destination written");

    property p_limm;
        cmd_wr && src1_limm |-> op1 == limm_r;
    endproperty
    a_limm: assert property (p_limm) else $error("long immediate not used");

endmodule

// *** verilog/iad_pkg.sv ***
package iad_pkg;

    localparam int unsigned DW = 32;
    localparam int unsigned AW = 8;
    localparam int unsigned SW = 4;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned REG_IDX_W = 3;
    localparam int unsigned NREGS = 8;

    // register offsets (byte addresses)
    localparam logic [AW-1:0] ADR_SRC1 = 8'h00;
    localparam logic [AW-1:0] ADR_SRC2 = 8'h04;
    localparam logic [AW-1:0] ADR_LIMM = 8'h08;
    localparam logic [AW-1:0] ADR_CMD = 8'h0c;
    localparam logic [AW-1:0] ADR_RESULT = 8'h10;
    localparam logic [AW-1:0] ADR_FLAGS = 8'h14;
    localparam logic [AW-1:0] ADR_RF_BASE = 8'h40;
    localparam logic [AW-1:0] ADR_RF_MASK = 8'he0;
    localparam int unsigned ADR_WORD_LSB = 2;

    // command word layout
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_OP_W = 3;
    localparam int unsigned CMD_SETF_BIT = 3;
    localparam int unsigned CMD_COND_LSB = 4;
    localparam int unsigned CMD_COND_W = 5;
    localparam int unsigned CMD_DEST_LSB = 9;
    localparam int unsigned CMD_SRC1_LIMM_BIT = 12;
    localparam int unsigned CMD_SRC2_LIMM_BIT = 13;
    localparam int unsigned CMD_SHORT_OFF_BIT = 14;
    localparam int unsigned CMD_OFF_LSB = 15;
    localparam int unsigned OFF_W = 5;
    localparam int unsigned OFF_ALIGN_W = 2;

    // flag register layout
    localparam int unsigned FLG_W = 5;
    localparam int unsigned FLG_Z = 0;
    localparam int unsigned FLG_N = 1;
    localparam int unsigned FLG_C = 2;
    localparam int unsigned FLG_V = 3;
    localparam int unsigned FLG_S = 4;
    localparam logic [FLG_W-1:0] FLAGS_RST = 5'h00;

    localparam logic [HALF_W-1:0] HALF_MAX = 16'h7fff;
    localparam logic [HALF_W-1:0] HALF_MIN = 16'h8000;
    localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
    localparam logic [DW-1:0] WORD_ZERO = 32'h0000_0000;
    localparam int unsigned SCALE_TWO = 1;
    localparam int unsigned SCALE_FOUR = 2;
    localparam int unsigned SCALE_EIGHT = 3;

    typedef enum logic [CMD_OP_W-1:0] {
        OP_HALFWORD_ABS_SATURATE = 3'h0,
        OP_SUM_WITH_CARRY = 3'h1,
        OP_SUM = 3'h2,
        OP_SUM_SCALED_BY_TWO = 3'h3,
        OP_SUM_SCALED_BY_FOUR = 3'h4,
        OP_SUM_SCALED_BY_EIGHT = 3'h5
    } iad_op_t;

    localparam logic [CMD_COND_W-1:0] COND_ALWAYS = 5'h00;
    localparam logic [CMD_COND_W-1:0] COND_ZERO = 5'h01;
    localparam logic [CMD_COND_W-1:0] COND_NONZERO = 5'h02;
    localparam logic [CMD_COND_W-1:0] COND_POSITIVE = 5'h03;
    localparam logic [CMD_COND_W-1:0] COND_NEGATIVE = 5'h04;
    localparam logic [CMD_COND_W-1:0] COND_CARRY = 5'h05;
    localparam logic [CMD_COND_W-1:0] COND_NOCARRY = 5'h06;
    localparam logic [CMD_COND_W-1:0] COND_OVF = 5'h07;
    localparam logic [CMD_COND_W-1:0] COND_NOOVF = 5'h08;
    localparam logic [CMD_COND_W-1:0] COND_SGT = 5'h09;
    localparam logic [CMD_COND_W-1:0] COND_SGE = 5'h0a;
    localparam logic [CMD_COND_W-1:0] COND_SLT = 5'h0b;
    localparam logic [CMD_COND_W-1:0] COND_SLE = 5'h0c;
    localparam logic [CMD_COND_W-1:0] COND_UGT = 5'h0d;
    localparam logic [CMD_COND_W-1:0] COND_ULE = 5'h0e;

    // evaluates a condition code against the current flags; unused codes are false
    function automatic logic iad_cond_true(input logic [CMD_COND_W-1:0] code, input logic [FLG_W-1:0] f);
        logic z;
        logic n;
        logic c;
        logic v;
        logic r;
        z = f[FLG_Z];
        n = f[FLG_N];
        c = f[FLG_C];
        v = f[FLG_V];
        case (code)
            COND_ALWAYS: r = 1'b1;
            COND_ZERO: r = z;
            COND_NONZERO: r = !z;
            COND_POSITIVE: r = !n;
            COND_NEGATIVE: r = n;
            COND_CARRY: r = c;
            COND_NOCARRY: r = !c;
            COND_OVF: r = v;
            COND_NOOVF: r = !v;
            COND_SGT: r = !z && (n == v);
            COND_SGE: r = (n == v);
            COND_SLT: r = (n != v);
            COND_SLE: r = z || (n != v);
            COND_UGT: r = !c && !z;
            COND_ULE: r = c || z;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // merges a write under byte enables
    function automatic logic [DW-1:0] iad_merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                                input logic [SW-1:0] sel);
        logic [DW-1:0] r;
        r = old;
        for (int i = 0; i < SW; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// *** verilog/iad_alu.sv ***
module iad_alu
    import iad_pkg::*;
(
    input wire iad_op_t op_i,
    input wire logic [DW-1:0] a_i,
    input wire logic [DW-1:0] b_i,
    input wire logic carry_i,
    output logic [DW-1:0] res_o,
    output logic z_o,
    output logic n_o,
    output logic c_o,
    output logic v_o,
    output logic sat_o
);

    logic [HALF_W-1:0] src16;
    logic [HALF_W-1:0] neg16;
    logic [DW-1:0] b_sh;
    logic [DW:0] sum;
    logic cin;
    logic is_abs;

    assign src16 = a_i[HALF_W-1:0];
    assign neg16 = HALF_ZERO - src16;
    assign is_abs = (op_i == OP_HALFWORD_ABS_SATURATE);
    assign cin = (op_i == OP_SUM_WITH_CARRY) ? carry_i : 1'b0;

    always_comb begin
        case (op_i)
            OP_SUM_SCALED_BY_TWO: b_sh = b_i << SCALE_TWO;
            OP_SUM_SCALED_BY_FOUR: b_sh = b_i << SCALE_FOUR;
            OP_SUM_SCALED_BY_EIGHT: b_sh = b_i << SCALE_EIGHT;
            default: b_sh = b_i;
        endcase
    end

    assign sum = {1'b0, a_i} + {1'b0, b_sh} + {{DW{1'b0}}, cin};

    always_comb begin
        sat_o = 1'b0;
        if (is_abs) begin
            if (src16 <= HALF_MAX) begin
                res_o = {HALF_ZERO, src16};
            end else if (src16 == HALF_MIN) begin
                res_o = {HALF_ZERO, HALF_MAX};
                sat_o = 1'b1;
            end else begin
                res_o = {HALF_ZERO, neg16};
            end
        end else begin
            res_o = sum[DW-1:0];
        end
    end

    // abs flags follow the input, carry unchanged
    assign z_o = is_abs ? (a_i == WORD_ZERO) : (res_o == WORD_ZERO);
    assign n_o = is_abs ? a_i[DW-1] : res_o[DW-1];
    assign c_o = is_abs ? carry_i : sum[DW];
    // overflow from the add step only, bits shifted out ignored
    assign v_o = is_abs ? sat_o :
                 (a_i[DW-1] == b_sh[DW-1]) && (res_o[DW-1] != a_i[DW-1]);

endmodule

// *** dv/iad_wb_model.sv ***
// bus side of the decode stage: one classic cycle per call
module iad_wb_model
    import iad_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [DW-1:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [AW-1:0] adr_o,
    output logic [SW-1:0] sel_o,
    output logic [DW-1:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    bit tmo = 1'b0;
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end
    task automatic xfer(input logic we, input logic [AW-1:0] a, input logic [SW-1:0] s,
                        input logic [DW-1:0] d, output logic [DW-1:0] q);
        int k;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_i !== 1'b1 && k < 16);
        if (ack_i !== 1'b1) begin
            tmo = 1'b1;
        end
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // released lines must not keep showing the last value
        adr_o <= ~a;
        sel_o <= ~s;
        dat_o <= ~d;
    endtask
endmodule

// *** dv/test_integer_add_abs_datapath.sv ***
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_integer_add_abs_datapath;
    timeunit 1ns;
    timeprecision 1ps;
    import iad_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [AW-1:0] wb_adr;
    logic [SW-1:0] wb_sel;
    logic [DW-1:0] wb_dat_w, wb_dat_r;
    logic [FLG_W-1:0] flags;
    int fail_count = 0;
    int n_checks = 0;
    logic [FLG_W-1:0] fm;
    logic [DW-1:0] rm, s1, s2, lm, cmd, rd;
    logic [DW-1:0] rfm [NREGS];
    logic [DW-1:0] corners [8] = '{32'hffff_8000, 32'h0000_7fff, 32'h0000_0000, 32'h8000_0000,
                                   32'h1234_8001, 32'hffff_ffff, 32'h7fff_0000, 32'h0000_8000};
    always #12.5 clk_sys_i = ~clk_sys_i;
    iad_top iad_top_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
        .wb_ack_o(wb_ack), .flags_o(flags));
    iad_wb_model iad_wb_model_i (.clk_i(clk_sys_i), .ack_i(wb_ack), .dat_i(wb_dat_r), .cyc_o(wb_cyc),
        .stb_o(wb_stb), .we_o(wb_we), .adr_o(wb_adr), .sel_o(wb_sel), .dat_o(wb_dat_w));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic bus(input logic we, input logic [AW-1:0] a, input logic [SW-1:0] s, input logic [DW-1:0] d);
        iad_wb_model_i.xfer(we, a, s, d, rd);
        if (iad_wb_model_i.tmo) begin
            fail_count++;
            $display("MISMATCH bus_ack exp 1 got 0");
            wrap_up;
        end
    endtask
    // reference behaviour of one command write
    task automatic model_exec;
        logic [DW-1:0] a, b, bs, r;
        logic [DW:0] w;
        logic [14:0] cv;
        logic [2:0] op;
        logic z, n, cf, vf, go, sat;
        op = cmd[2:0];
        a = cmd[12] ? lm : s1;
        b = cmd[14] ? {25'h0, cmd[19:15], 2'b00} : (cmd[13] ? lm : s2);
        {vf, cf, n, z} = fm[3:0];
        cv = {cf | z, !cf & !z, z | (n ^ vf), n ^ vf, !(n ^ vf), !z & !(n ^ vf), !vf, vf, !cf, cf, n, !n, !z, z, 1'b1};
        go = cmd[8:4] < 5'h0f && cv[cmd[7:4]];
        bs = b << (op == 3'h3 ? 1 : op == 3'h4 ? 2 : op == 3'h5 ? 3 : 0);
        w = {1'b0, a} + {1'b0, bs} + {32'h0, op == 3'h1 && cf};
        r = w[DW-1:0];
        sat = a[15:0] == 16'h8000;
        if (op == 3'h0) begin
            r = a[15:0] <= 16'h7fff ? {16'h0, a[15:0]} : sat ? 32'h0000_7fff : {16'h0, 16'h0 - a[15:0]};
        end
        if (go) begin
            rm = r;
            if (cmd[11:9] != 3'h0) begin
                rfm[cmd[11:9]] = r;
            end
            if (cmd[3]) begin
                if (op == 3'h0) begin
                    fm = {fm[4] | sat, sat, cf, a[31], a == 32'h0};
                end else begin
                    fm = {fm[4], a[31] == bs[31] && r[31] != a[31], w[DW], r[31], r == 32'h0};
                end
            end
        end
    endtask
    initial begin
        void'($urandom(32'h9d9f1e29));
        fm = 5'h00;
        rm = 32'h0;
        foreach (rfm[j]) rfm[j] = 32'h0;
        repeat (3) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        `CHK("flags_rst", FLAGS_RST, flags)
        bus(1'b0, ADR_RESULT, 4'hf, 32'h0);
        `CHK("result_rst", 32'h0, rd)
        $display("test reset done");
        bus(1'b1, ADR_SRC1, 4'hf, 32'h1111_1111);
        bus(1'b1, ADR_SRC1, 4'h5, 32'haabb_ccdd);
        bus(1'b0, ADR_SRC1, 4'hf, 32'h0);
        `CHK("src1_merge", 32'h11bb_11dd, rd)
        @(posedge clk_sys_i);
        `CHK("dat_idle", 32'h0, wb_dat_r)
        `CHK("ack_idle", 1'b0, wb_ack)
        bus(1'b1, ADR_RESULT, 4'hf, 32'h5a5a_5a5a);
        bus(1'b0, ADR_RESULT, 4'hf, 32'h0);
        `CHK("result_ro", 32'h0, rd)
        bus(1'b0, ADR_CMD, 4'hf, 32'h0);
        `CHK("cmd_read", 32'h0, rd)
        bus(1'b0, 8'h20, 4'hf, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        $display("test registers done");
        for (int i = 0; i < 300; i++) begin
            s1 = i < 8 ? corners[i] : $urandom();
            lm = i < 8 ? corners[i] : $urandom();
            s2 = $urandom();
            cmd = $urandom();
            cmd[2:0] = i < 8 ? 3'h0 : 3'(i);
            cmd[8:4] = (i >= 8 && i < 40) ? 5'(i - 8) : (cmd[31] ? {1'b0, cmd[7:4]} : COND_ALWAYS);
            if (i < 8) begin
                cmd[3] = 1'b1;
            end
            fm = 5'($urandom());
            bus(1'b1, ADR_FLAGS, 4'hf, {27'h0, fm});
            bus(1'b1, ADR_SRC1, 4'hf, s1);
            bus(1'b1, ADR_SRC2, 4'hf, s2);
            bus(1'b1, ADR_LIMM, 4'hf, lm);
            bus(1'b1, ADR_CMD, 4'hf, cmd);
            model_exec();
            `CHK("flags", fm, flags)
            bus(1'b0, ADR_RESULT, 4'hf, 32'h0);
            `CHK("result", rm, rd)
            bus(1'b0, ADR_FLAGS, 4'hf, 32'h0);
            `CHK("flags_reg", {27'h0, fm}, rd)
            for (int j = 0; j < NREGS; j++) begin
                bus(1'b0, ADR_RF_BASE + 8'(4 * j), 4'hf, 32'h0);
                `CHK("regfile", rfm[j], rd)
            end
        end
        $display("test datapath done");
        wrap_up;
    end
endmodule
